// file: strobe_mux_pkg.sv
package strobe_mux_pkg;

  // Parallel port mode field codes.
  localparam logic [1:0] MODE_MEM_A  = 2'h0;
  localparam logic [1:0] MODE_MEM_B  = 2'h1;
  localparam logic [1:0] MODE_HOST_A = 2'h2;
  localparam logic [1:0] MODE_HOST_B = 2'h3;
  localparam int         MODE_HOST_BIT = 1;

  // Terminal indices on the pad bus.
  localparam int TERM_COUNT  = 4;
  localparam int TERM_COLUMN = 0;
  localparam int TERM_WRITE  = 1;
  localparam int TERM_ADDR10 = 2;
  localparam int TERM_CLOCK  = 3;

  // Synchroniser depth and reset levels.
  localparam int                    SYNC_STAGES  = 2;
  localparam logic [TERM_COUNT-1:0] PAD_RESET    = 4'hF;
  localparam logic [TERM_COUNT-1:0] OE_RESET     = 4'h0;
  localparam logic                  HOST_IDLE    = 1'h1;
  localparam logic                  STRAP_RESET  = 1'h1;
  localparam logic                  NO_PRECHARGE = 1'h0;

  // Strap capture sequence after reset release.
  typedef enum logic [1:0] {
    BOOT_FILL1,
    BOOT_FILL2,
    BOOT_CAPTURE,
    BOOT_RUN
  } boot_state_t;

  // Signals from the device's SDRAM controller.
  typedef struct packed {
    logic column_strobe_n;
    logic write_enable_n;
    logic addr10;
    logic row_a12;
    logic activate_cmd;
    logic rw_cmd;
    logic mem_clock;
  } mem_side_t;

  // Signals handed to the host port and general I/O logic.
  typedef struct packed {
    logic select_n;
    logic data_strobe_one;
    logic data_strobe_two;
    logic io_thirteen_in;
  } host_side_t;

endpackage

// file: pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH  = 1,
  parameter int STAGES = 2
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_ff [STAGES];
  logic [WIDTH-1:0] nxt_stage [STAGES];

  // Shift chain; only the next stage, or the output for the last, reads each flop.
  always_comb begin
    nxt_stage[0] = async_in;
    for (int i = 1; i < STAGES; i++) begin
      nxt_stage[i] = stage_ff[i-1];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_ff[i] <= '0;
      end
    end else if (clk_en) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_ff[i] <= nxt_stage[i];
      end
    end
  end

  assign sync_out = stage_ff[STAGES-1];

endmodule

// file: parallel_port_strobe_pin_mux.sv
`timescale 1ns/1ps
module parallel_port_strobe_pin_mux (
  input  wire logic                                  mclk,
  input  wire logic                                  rst,
  input  wire logic                                  clk_en,
  input  wire logic [1:0]                            port_mode,
  input  wire logic                                  port_mode_load,
  input  wire logic                                  boot_function_select_pin,
  input  wire strobe_mux_pkg::mem_side_t             mem_side,
  input  wire logic                                  general_io_thirteen_out,
  input  wire logic                                  general_io_thirteen_oe,
  input  wire logic [strobe_mux_pkg::TERM_COUNT-1:0] pad_in,
  output logic      [strobe_mux_pkg::TERM_COUNT-1:0] pad_out,
  output logic      [strobe_mux_pkg::TERM_COUNT-1:0] pad_oe,
  output strobe_mux_pkg::host_side_t                 host_side,
  output logic                                       memory_mode
);
  import strobe_mux_pkg::*;

  // Memory functions own the terminals whenever the upper mode bit is clear.
  function automatic logic is_mem_mode(input logic [1:0] mode);
    is_mem_mode = ~mode[MODE_HOST_BIT];
  endfunction

  logic [TERM_COUNT-1:0] pad_sync;
  logic                  boot_sync;

  // Pads and the strap pin come from outside the clock domain.
  pin_sync #(
    .WIDTH  (TERM_COUNT + 1),
    .STAGES (SYNC_STAGES)
  ) u_pin_sync (
    .mclk     (mclk),
    .rst      (rst),
    .clk_en   (clk_en),
    .async_in ({boot_function_select_pin, pad_in}),
    .sync_out ({boot_sync, pad_sync})
  );

  // Boot sequencer state, captured strap and the software-loaded mode.
  boot_state_t boot_ff;
  boot_state_t nxt_boot;
  logic        strap_ff;
  logic        nxt_strap;
  logic [1:0]  mode_ff;
  logic [1:0]  nxt_mode;
  logic        loaded_ff;
  logic        nxt_loaded;

  // The strap cannot be caught under asynchronous reset, so it is sampled
  // once the synchroniser has filled after release.
  always_comb begin
    nxt_boot   = boot_ff;
    nxt_strap  = strap_ff;
    nxt_loaded = loaded_ff;
    nxt_mode   = mode_ff;
    case (boot_ff)
      BOOT_FILL1: begin
        nxt_boot = BOOT_FILL2;
      end
      BOOT_FILL2: begin
        nxt_boot = BOOT_CAPTURE;
      end
      BOOT_CAPTURE: begin
        nxt_strap = boot_sync;
        nxt_boot  = BOOT_RUN;
      end
      BOOT_RUN: begin
        if (port_mode_load) begin
          nxt_loaded = 1'h1;
          nxt_mode   = port_mode;
        end
      end
      default: begin
        nxt_boot = BOOT_FILL1;
      end
    endcase
  end

  // Reset leaves the strap at memory and no software mode loaded.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      boot_ff   <= BOOT_FILL1;
      strap_ff  <= STRAP_RESET;
      loaded_ff <= 1'h0;
      mode_ff   <= MODE_MEM_A;
    end else if (clk_en) begin
      boot_ff   <= nxt_boot;
      strap_ff  <= nxt_strap;
      loaded_ff <= nxt_loaded;
      mode_ff   <= nxt_mode;
    end
  end

  // Mode in force this cycle and whether the strap has been taken.
  logic [1:0] eff_mode;
  logic       running;

  // Until software loads a mode, the strap picks memory or host functions.
  always_comb begin
    running = (boot_ff == BOOT_RUN);
    if (port_mode_load && running) begin
      eff_mode = port_mode;
    end else if (loaded_ff) begin
      eff_mode = mode_ff;
    end else if (strap_ff) begin
      eff_mode = MODE_MEM_A;
    end else begin
      eff_mode = MODE_HOST_A;
    end
  end

  // Per-terminal memory levels, drive enables and their registered copies.
  logic                  row_ctl;
  logic [TERM_COUNT-1:0] mem_level;
  logic [TERM_COUNT-1:0] mem_drive;
  logic [TERM_COUNT-1:0] pad_out_ff;
  logic [TERM_COUNT-1:0] nxt_pad_out;
  logic [TERM_COUNT-1:0] pad_oe_ff;
  logic [TERM_COUNT-1:0] nxt_pad_oe;
  logic                  mem_ff;
  logic                  nxt_mem;

  // Address ten carries A12 on activate and a low level on accesses.
  always_comb begin
    if (mem_side.activate_cmd) begin
      row_ctl = mem_side.row_a12;
    end else if (mem_side.rw_cmd) begin
      row_ctl = NO_PRECHARGE;
    end else begin
      row_ctl = mem_side.addr10;
    end
    mem_level[TERM_COLUMN] = mem_side.column_strobe_n;
    mem_level[TERM_WRITE]  = mem_side.write_enable_n;
    mem_level[TERM_ADDR10] = row_ctl;
    mem_level[TERM_CLOCK]  = mem_side.mem_clock;
  end

  // Drivers stay off until the strap is known, so the keeper holds the pins.
  always_comb begin
    nxt_mem   = running && is_mem_mode(eff_mode);
    mem_drive = {TERM_COUNT{nxt_mem}};
  end

  // Per terminal: drive the memory level, on address ten in host modes the general I/O thirteen level, or else keep the last one.
  for (genvar t = 0; t < TERM_COUNT; t++) begin : g_term
    always_comb begin
      if (mem_drive[t]) begin
        nxt_pad_out[t] = mem_level[t];
        nxt_pad_oe[t]  = 1'h1;
      end else if (t == TERM_ADDR10 && running && !is_mem_mode(eff_mode)) begin
        // General I/O thirteen keeps its own driver in the host modes.
        nxt_pad_out[t] = general_io_thirteen_out;
        nxt_pad_oe[t]  = general_io_thirteen_oe;
      end else begin
        nxt_pad_out[t] = pad_out_ff[t];
        nxt_pad_oe[t]  = 1'h0;
      end
    end
  end

  // Pad drive, enables and the mode flag are registered so every output comes from a flop.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pad_out_ff <= PAD_RESET;
      pad_oe_ff  <= OE_RESET;
      mem_ff     <= 1'h0;
    end else if (clk_en) begin
      pad_out_ff <= nxt_pad_out;
      pad_oe_ff  <= nxt_pad_oe;
      mem_ff     <= nxt_mem;
    end
  end

  // Registered view of the host-port inputs.
  host_side_t host_ff;
  host_side_t nxt_host;

  // Host inputs read idle while the memory functions own the pins, so a
  // stray select cannot reach the host port during SDRAM traffic.
  always_comb begin
    if (running && !is_mem_mode(eff_mode)) begin
      nxt_host.select_n        = pad_sync[TERM_COLUMN];
      nxt_host.data_strobe_one = pad_sync[TERM_WRITE];
      nxt_host.data_strobe_two = pad_sync[TERM_CLOCK];
    end else begin
      nxt_host.select_n        = HOST_IDLE;
      nxt_host.data_strobe_one = HOST_IDLE;
      nxt_host.data_strobe_two = HOST_IDLE;
    end
    nxt_host.io_thirteen_in = pad_sync[TERM_ADDR10];
  end

  // Host inputs reset to their idle levels; the general input resets low.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      host_ff <= '{HOST_IDLE, HOST_IDLE, HOST_IDLE, 1'h0};
    end else if (clk_en) begin
      host_ff <= nxt_host;
    end
  end

  // Outputs are taken straight from their flops.
  assign pad_out     = pad_out_ff;
  assign pad_oe      = pad_oe_ff;
  assign host_side   = host_ff;
  assign memory_mode = mem_ff;

endmodule

// file: host_model.sv
`timescale 1ns/1ps
module host_model (
  input  wire logic [3:0] pad_out,
  input  wire logic [3:0] pad_oe,
  input  wire logic [3:0] host_lvl,
  output logic      [3:0] pad_in
);
  // A pin shows the device's level while it drives, else the host's select, strobe or general I/O level.
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      pad_in[k] = pad_oe[k] ? pad_out[k] : host_lvl[k];
    end
  end
endmodule

// file: pin_mux_checker.sv
`timescale 1ns/1ps
module pin_mux_checker (
  input wire logic                                  mclk,
  input wire logic                                  rst,
  input wire logic                                  clk_en,
  input wire strobe_mux_pkg::mem_side_t             mem_side,
  input wire logic [strobe_mux_pkg::TERM_COUNT-1:0] pad_in,
  input wire logic [strobe_mux_pkg::TERM_COUNT-1:0] pad_out,
  input wire logic [strobe_mux_pkg::TERM_COUNT-1:0] pad_oe,
  input wire strobe_mux_pkg::host_side_t            host_side,
  input wire logic                                  memory_mode
);
  import strobe_mux_pkg::*;
  logic [2:0] run_ff;
  logic [2:0] nxt_run;
  logic       prev_ff;
  logic       nxt_prev;
  // Past values are trusted only after five enabled edges in a row, so boot and freezes stay quiet.
  always_comb begin
    nxt_run = !clk_en ? 3'h0 : (run_ff == 3'h7 ? run_ff : run_ff + 3'h1);
    nxt_prev = memory_mode;
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      run_ff <= 3'h0;
      prev_ff <= 1'h0;
    end else begin
      run_ff <= nxt_run;
      prev_ff <= nxt_prev;
    end
  end
  wire mem2  = run_ff >= 3'h5 && memory_mode && prev_ff;
  wire host2 = run_ff >= 3'h5 && !memory_mode && !prev_ff;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_col_route: assert property (mem2 |-> pad_out[0] == $past(mem_side.column_strobe_n))
    else $error("column pad wrong");
  a_write_route: assert property (mem2 |-> pad_out[1] == $past(mem_side.write_enable_n))
    else $error("write pad wrong");
  a_clock_route: assert property (mem2 |-> pad_out[3] == $past(mem_side.mem_clock))
    else $error("clock pad wrong");
  a_row_addr: assert property (mem2 && $past(mem_side.activate_cmd) |-> pad_out[2] == $past(mem_side.row_a12))
    else $error("row bit wrong");
  a_no_precharge: assert property (mem2 && $past(!mem_side.activate_cmd && mem_side.rw_cmd) |-> !pad_out[2])
    else $error("precharge bit wrong");
  a_oe_dir: assert property (run_ff >= 3'h5 |-> {pad_oe[3], pad_oe[1:0]} == {3{memory_mode}})
    else $error("pad direction wrong");
  a_keeper_hold: assert property (host2 |-> $stable({pad_out[3], pad_out[1:0]}))
    else $error("keeper level moved");
  a_host_select: assert property (host2[*3] |-> host_side.select_n == $past(pad_in[0], 3))
    else $error("host select wrong");
endmodule
bind parallel_port_strobe_pin_mux pin_mux_checker chk_i (
  .mclk(mclk), .rst(rst), .clk_en(clk_en), .mem_side(mem_side), .pad_in(pad_in),
  .pad_out(pad_out), .pad_oe(pad_oe), .host_side(host_side), .memory_mode(memory_mode)
);

// file: tb_parallel_port_strobe_pin_mux.sv
`timescale 1ns/1ps
module tb_parallel_port_strobe_pin_mux;
  import strobe_mux_pkg::*;
  logic       mclk = 1'h0;
  logic       rst = 1'h1;
  logic       clk_en = 1'h1;
  logic [1:0] port_mode = 2'h0;
  logic       port_mode_load = 1'h0;
  logic       strap = 1'h1;
  mem_side_t  ms = '0;
  logic       io_out = 1'h0;
  logic       io_oe = 1'h0;
  logic [3:0] host_lvl = 4'hF;
  logic [3:0] pad_in;
  logic [3:0] pad_out;
  logic [3:0] pad_oe;
  host_side_t hs;
  logic       mem_mode;
  int         miscompares = 0;
  int         cmp_count = 0;
  // Free-running clock at 40 MHz.
  always #12.5 mclk = ~mclk;
  parallel_port_strobe_pin_mux dut (
    .mclk(mclk), .rst(rst), .clk_en(clk_en), .port_mode(port_mode), .port_mode_load(port_mode_load),
    .boot_function_select_pin(strap), .mem_side(ms), .general_io_thirteen_out(io_out),
    .general_io_thirteen_oe(io_oe), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .host_side(hs), .memory_mode(mem_mode)
  );
  host_model partner (.pad_out(pad_out), .pad_oe(pad_oe), .host_lvl(host_lvl), .pad_in(pad_in));
  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic load(input logic [1:0] m);
    port_mode = m;
    port_mode_load = 1'h1;
    step(1);
    port_mode_load = 1'h0;
    step(1);
  endtask
  // Reset with a given strap; an early load must be ignored until the strap is captured.
  // The general I/O driver is switched off so the strap alone sets the enables.
  task automatic boot(input logic s);
    rst = 1'h1;
    strap = s;
    io_oe = 1'h0;
    step(10);
    chk("reset pads", {pad_oe, pad_out}, 8'h0F);
    rst = 1'h0;
    port_mode = s ? 2'h2 : 2'h0;
    port_mode_load = 1'h1;
    step(1);
    port_mode_load = 1'h0;
    step(4);
    chk("strap mode", mem_mode, s);
    chk("strap oe", pad_oe, {4{s}});
  endtask
  // Every memory-side pattern, so address ten priority is seen in all combinations.
  task automatic mem_routes(input logic [1:0] m);
    logic [3:0] exp_pads;
    load(m);
    for (int i = 0; i < 128; i++) begin
      ms = mem_side_t'(i[6:0]);
      step(1);
      exp_pads = {ms.mem_clock, ms.activate_cmd ? ms.row_a12 : (!ms.rw_cmd & ms.addr10),
                  ms.write_enable_n, ms.column_strobe_n};
      chk("mem pads", pad_out, exp_pads);
      chk("host idle", {pad_oe, 1'h0, hs[3:1]}, 8'hF7);
    end
  endtask
  task automatic host_routes(input logic [1:0] m);
    load(m);
    ms = 7'h55;
    for (int j = 0; j < 16; j++) begin
      host_lvl = j[3:0];
      io_oe = j[1];
      io_out = ~j[2];
      step(4);
      chk("host oe", {mem_mode, pad_oe}, {3'h0, io_oe, 2'h0});
      chk("keeper", {pad_out[3], pad_out[1:0]}, 3'h2);
      chk("host side", hs, {j[0], j[1], j[3], j[1] ? io_out : j[2]});
    end
  endtask
  // Clock enable low must freeze every flop; the pads catch up on the first enabled edge.
  task automatic freeze();
    ms = 7'h2A;
    clk_en = 1'h0;
    step(3);
    chk("frozen pads", {mem_mode, pad_out}, 8'h1F);
    clk_en = 1'h1;
    step(1);
    chk("thawed pads", {mem_mode, pad_out}, 8'h12);
  endtask
  task automatic wrap_up();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    boot(1'h1);
    mem_routes(2'h0);
    mem_routes(2'h1);
    freeze();
    host_routes(2'h2);
    host_routes(2'h3);
    boot(1'h0);
    wrap_up();
  end
  // The run needs about 430 cycles; a hang is cut off well beyond that.
  initial begin
    repeat (3000) @(posedge mclk);
    miscompares++;
    wrap_up();
  end
endmodule
